/* wsw_watchdog.sv */
// watchdog timer with sleep entry and wake-up control
// Behaviour
// R01 - watchdog counts on the 31 kHz low-frequency oscillator tick, not the system clock
// R02 - dedicated 16-bit prescaler, plus optional shared 8-bit timer prescaler
// R03 - periods span roughly 1 ms to 268 s over combined prescaler settings
// R04 - control register resets to 0 1000: 17 ms base, soft enable off
// R05 - watchdog held in reset during oscillator start-up timer, resumes if enabled
// R06 - fuse set: watchdog always runs, soft enable ignored
// R07 - fuse clear: soft enable bit 0 turns watchdog on or off
// R08 - period select bits 4-1: 1:32 doubling to 1:65536, codes 12-15 reserved
// R09 - cleared when disabled, on clear instruction, oscillator fail, non-crystal sleep exit
// R10 - crystal-mode sleep exit keeps watchdog cleared until start-up timer ends
// R11 - sleep clears watchdog, clears power-down flag, sets timeout flag, freezes pins
// R12 - watchdog reset is internal and never drives master clear low
// R13 - master clear in sleep resets; watchdog or interrupt wake resumes execution
// R14 - power-down flag set at power-up, cleared on sleep; timeout cleared by watchdog wake
// R15 - only asynchronous wake sources can wake the device during sleep
// R16 - any enabled interrupt wakes; global enable picks in-line or vector 0004h
// R17 - sleep prefetches the next instruction for use on wake
// R18 - pending enabled interrupt before sleep turns sleep into no-operation
// R19 - interrupt during sleep: sleep completes, then immediate wake with all effects
// R20 - watchdog cleared on every wake from sleep
// R21 - crystal modes wait 1024 oscillator periods on wake, other modes none
// R22 - software should clear watchdog just before sleep
// R23 - terminal count resets device when awake, wakes it when asleep
//
// Chosen here: the address map and the Wishbone interface to the registers.
module wsw_watchdog
    import wsw_pkg::*;
#(
    parameter int LF_DIVIDE = LF_DIV,
    parameter int OST_COUNT = OST_PERIODS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration fuse word
    input wire logic [7:0] fuse_word_i,
    // power-on indication and master clear
    input wire logic power_on_i,
    input wire logic master_clear_i,
    // core events and interrupt sources
    input wire wsw_pkg::wsw_core_ev_t core_ev_i,
    input wire wsw_pkg::wsw_irq_src_t irq_src_i,
    input wire logic osc_period_i,
    // outputs to core
    output logic device_reset_o,
    output logic asleep_o,
    output logic osc_driver_off_o,
    output logic io_hold_o,
    output logic wake_o,
    output logic wake_vector_o,
    output logic prefetch_o,
    output logic sleep_nop_o
);
    import wsw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] irq_ctrl_q;
    logic [5:0] pin_chg_q;
    logic [7:0] peri_flag_q;
    logic [7:0] peri_en_q;
    logic [4:0] wdt_ctrl_q;
    logic [7:0] prescale_q;
    logic timeout_flag_q;
    logic powerdown_flag_q;
    wsw_state_t state_q;
    logic [15:0] ost_cnt_q;
    logic [15:0] lf_div_q;
    logic lf_tick;
    logic [WDT_PRE_BITS-1:0] wdt_pre_q;
    logic [TMR_PRE_BITS-1:0] tmr_pre_q;
    logic wdt_cnt_q;
    logic wdt_clear;
    logic wdt_enabled;
    logic wdt_expire;
    logic crystal_mode;
    logic pending;
    logic wake_any;
    logic wb_req;
    logic wb_wr;

    // one-hot select of the prescaler tap for a period code
    // reserved codes match no tap, so they never expire
    function automatic logic tap_hit(input logic [WDT_PRE_BITS-1:0] cnt, input logic [3:0] code);
        logic [WDT_PRE_BITS:0] mask;
        logic hit;
        hit = 1'b0;
        mask = '0;
        for (int i = 0; i <= int'(PS_MAX_CODE); i++) begin
            if (code == 4'(i)) begin
                // one extra bit so the widest tap still yields an all-ones mask
                mask = ({{WDT_PRE_BITS{1'b0}}, 1'b1} << (PS_BASE_LOG2 + i)) - 1'b1;
                hit = &(cnt | ~mask[WDT_PRE_BITS-1:0]);
            end
        end
        return hit;
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // enables and status
    assign wdt_enabled = fuse_word_i[FU_WDT_EN] || wdt_ctrl_q[WC_SOFT_EN]; // see R06 see R07
    assign crystal_mode = (fuse_word_i[FU_OSC_LSB +: 3] == OSC_LP) || (fuse_word_i[FU_OSC_LSB +: 3] == OSC_XT)
        || (fuse_word_i[FU_OSC_LSB +: 3] == OSC_HS);
    // enabled flag present; wake ignores the global enable
    // a latched flag counts, and so does one raised in this very cycle
    assign pending = (irq_ctrl_q[5] && (irq_ctrl_q[2] || irq_src_i.timer0))
        || (irq_ctrl_q[4] && (irq_ctrl_q[1] || irq_src_i.ext_pin))
        || (irq_ctrl_q[3] && (irq_ctrl_q[0] || irq_src_i.pin_change))
        || (irq_ctrl_q[IC_PERI_GATE] && |((peri_flag_q | irq_src_i.peri) & peri_en_q)); // see R16 see R18
    assign wake_any = (state_q == WSW_ASLEEP) && (pending || wdt_expire); // see R15 see R23

    ////////////////////////////////////////////////////////////////////////
    // low-frequency tick from the system clock
    always_ff @(posedge clk_i) begin
        if (rst_i || lf_tick) begin
            lf_div_q <= 16'h0000;
        end else begin
            lf_div_q <= lf_div_q + 16'h0001;
        end
    end
    assign lf_tick = (lf_div_q == 16'(LF_DIVIDE - 1)); // see R01

    ////////////////////////////////////////////////////////////////////////
    // prescalers and counter
    // watchdog is clear whenever a clear cause or the start-up timer is active
    assign wdt_clear = !wdt_enabled || core_ev_i.clear_watchdog_instr_exec || core_ev_i.osc_fail // see R09
        || (state_q == WSW_OST) // see R05 see R10
        || (state_q == WSW_AWAKE && core_ev_i.sleep_exec && !pending) // see R11 see R18
        || wake_any; // see R20
    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear) begin
            wdt_pre_q <= '0;
        end else if (lf_tick) begin
            wdt_pre_q <= wdt_pre_q + 1'b1; // see R02
        end
    end
    // shared timer prescaler stretches the period when assigned to the watchdog
    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear) begin
            tmr_pre_q <= '0;
        end else if (lf_tick && tap_hit(wdt_pre_q, wdt_ctrl_q[WC_PS_LSB +: 4]) && prescale_q[PR_ASSIGN]) begin
            tmr_pre_q <= tmr_pre_q + 1'b1; // see R02 see R03
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || wdt_clear) begin
            wdt_cnt_q <= 1'b0;
        end else begin
            wdt_cnt_q <= lf_tick && tap_hit(wdt_pre_q, wdt_ctrl_q[WC_PS_LSB +: 4]) // see R08
                && (!prescale_q[PR_ASSIGN] || &(tmr_pre_q | ~((8'h01 << prescale_q[2:0]) - 8'h01))); // see R03
        end
    end
    assign wdt_expire = wdt_cnt_q && wdt_enabled;

    ////////////////////////////////////////////////////////////////////////
    // sleep state machine
    always_ff @(posedge clk_i) begin
        if (rst_i || master_clear_i) begin
            state_q <= WSW_AWAKE; // see R13
        end else begin
            unique case (state_q)
                WSW_AWAKE: begin
                    if (core_ev_i.sleep_exec && !pending) begin
                        state_q <= WSW_ASLEEP; // see R18
                    end
                end
                WSW_ASLEEP: begin
                    if (wake_any) begin
                        state_q <= crystal_mode ? WSW_OST : WSW_AWAKE; // see R21
                    end
                end
                WSW_OST: begin
                    if (ost_cnt_q == 16'(OST_COUNT - 1) && osc_period_i) begin
                        state_q <= WSW_AWAKE;
                    end
                end
                default: state_q <= WSW_AWAKE;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != WSW_OST) begin
            ost_cnt_q <= 16'h0000;
        end else if (osc_period_i) begin
            ost_cnt_q <= ost_cnt_q + 16'h0001; // see R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
        end else if (power_on_i) begin
            powerdown_flag_q <= 1'b1; // see R14
            timeout_flag_q <= 1'b1;
        end else if (state_q == WSW_AWAKE && core_ev_i.sleep_exec && !pending) begin
            powerdown_flag_q <= 1'b0; // see R11 see R19
            timeout_flag_q <= 1'b1;
        end else if (wdt_expire) begin
            timeout_flag_q <= 1'b0; // see R14
        end else if (core_ev_i.clear_watchdog_instr_exec) begin
            powerdown_flag_q <= 1'b1;
            timeout_flag_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_reset_o <= 1'b0;
            wake_o <= 1'b0;
            wake_vector_o <= 1'b0;
            prefetch_o <= 1'b0;
            sleep_nop_o <= 1'b0;
        end else begin
            device_reset_o <= wdt_expire && state_q == WSW_AWAKE; // see R12 see R23
            wake_o <= wake_any; // see R13
            wake_vector_o <= wake_any && pending && irq_ctrl_q[IC_GLOBAL]; // see R16
            prefetch_o <= core_ev_i.sleep_exec; // see R17
            sleep_nop_o <= core_ev_i.sleep_exec && pending && state_q == WSW_AWAKE; // see R18
        end
    end
    // start-up wait is not sleep: the core is woken, only the pins stay held
    assign asleep_o = (state_q == WSW_ASLEEP);
    assign osc_driver_off_o = (state_q == WSW_ASLEEP); // see R11
    assign io_hold_o = (state_q != WSW_AWAKE); // see R11

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_ctrl_q <= RST_WDT_CTRL; // see R04
            prescale_q <= RST_PRESCALE;
            pin_chg_q <= RST_PIN_CHG;
            peri_en_q <= RST_PERI_EN;
        end else if (wb_wr) begin
            if (wb_adr_i == OFS_WDT_CTRL) begin
                wdt_ctrl_q <= wb_dat_i[4:0];
            end
            if (wb_adr_i == OFS_PRESCALE) begin
                prescale_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_PIN_CHG) begin
                pin_chg_q <= wb_dat_i[5:0];
            end
            if (wb_adr_i == OFS_PERI_EN) begin
                peri_en_q <= wb_dat_i[7:0];
            end
        end
    end
    // hardware sets win over software clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ctrl_q <= RST_IRQ_CTRL;
            peri_flag_q <= RST_PERI_FLAG;
        end else begin
            irq_ctrl_q <= ((wb_wr && wb_adr_i == OFS_IRQ_CTRL) ? wb_dat_i[7:0] : irq_ctrl_q)
                | {5'h00, irq_src_i.timer0, irq_src_i.ext_pin, irq_src_i.pin_change};
            peri_flag_q <= ((wb_wr && wb_adr_i == OFS_PERI_FLAG) ? wb_dat_i[7:0] : peri_flag_q) | irq_src_i.peri;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            unique case (wb_adr_i)
                OFS_IRQ_CTRL: wb_dat_o <= {24'h000000, irq_ctrl_q};
                OFS_PIN_CHG: wb_dat_o <= {26'h0, pin_chg_q};
                OFS_PERI_FLAG: wb_dat_o <= {24'h000000, peri_flag_q};
                OFS_PERI_EN: wb_dat_o <= {24'h000000, peri_en_q};
                OFS_WDT_CTRL: wb_dat_o <= {27'h0, wdt_ctrl_q};
                OFS_PRESCALE: wb_dat_o <= {24'h000000, prescale_q};
                OFS_FUSE: wb_dat_o <= {24'h000000, fuse_word_i};
                OFS_STATUS: wb_dat_o <= {28'h0000000, asleep_o, wdt_enabled, timeout_flag_q, powerdown_flag_q};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // wsw_watchdog

/* wsw_pkg.sv */
// package for the watchdog and sleep/wake control block
package wsw_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [3:0] ADDR_IRQ_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PIN_CHG = 4'h4;
    localparam logic [3:0] ADDR_PERI_FLAG = 4'h8;
    localparam logic [3:0] ADDR_PERI_EN = 4'hc;
    localparam logic [3:0] ADDR_WDT_CTRL = 4'h0;
    localparam logic [5:0] OFS_IRQ_CTRL = 6'h00;
    localparam logic [5:0] OFS_PIN_CHG = 6'h04;
    localparam logic [5:0] OFS_PERI_FLAG = 6'h08;
    localparam logic [5:0] OFS_PERI_EN = 6'h0c;
    localparam logic [5:0] OFS_WDT_CTRL = 6'h10;
    localparam logic [5:0] OFS_PRESCALE = 6'h14;
    localparam logic [5:0] OFS_FUSE = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h1c;
    // reset values
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [5:0] RST_PIN_CHG = 6'h00;
    localparam logic [7:0] RST_PERI_FLAG = 8'h00;
    localparam logic [7:0] RST_PERI_EN = 8'h00;
    localparam logic [4:0] RST_WDT_CTRL = 5'h08;
    localparam logic [7:0] RST_PRESCALE = 8'hff;
    // field positions
    localparam int IC_GLOBAL = 7;
    localparam int IC_PERI_GATE = 6;
    localparam int WC_SOFT_EN = 0;
    localparam int WC_PS_LSB = 1;
    localparam int PR_ASSIGN = 3;
    localparam int FU_WDT_EN = 3;
    localparam int FU_OSC_LSB = 0;
    // period select: code 0 is 1:32, doubling up to code 11
    localparam logic [3:0] PS_MAX_CODE = 4'hb;
    localparam int PS_BASE_LOG2 = 5;
    // oscillator modes in the fuse word
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;
    // timing
    localparam int LFOSC_HZ = 31000;
    localparam int SYS_HZ = 250000000;
    localparam int LF_DIV = SYS_HZ / LFOSC_HZ;
    localparam int OST_PERIODS = 1024;
    // prescaler sizes
    localparam int WDT_PRE_BITS = 16;
    localparam int TMR_PRE_BITS = 8;

    typedef enum logic [1:0] {
        WSW_AWAKE,
        WSW_ASLEEP,
        WSW_OST
    } wsw_state_t;

    // core events that reach this block
    typedef struct packed {
        logic sleep_exec;
        logic clear_watchdog_instr_exec;
        logic osc_fail;
    } wsw_core_ev_t;

    // wake-capable interrupt sources
    typedef struct packed {
        logic ext_pin;
        logic pin_change;
        logic timer0;
        logic [7:0] peri;
    } wsw_irq_src_t;
endpackage : wsw_pkg

/* wsw_props.sv */
// assertion checker for the watchdog and sleep/wake block
module wsw_props
    import wsw_pkg::*;
#(
    parameter int OST_COUNT = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus and configuration
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [7:0] fuse_word_i,
    input wire wsw_pkg::wsw_core_ev_t core_ev_i,
    // block outputs
    input wire logic device_reset_o,
    input wire logic asleep_o,
    input wire logic osc_driver_off_o,
    input wire logic io_hold_o,
    input wire logic wake_o,
    input wire logic wake_vector_o,
    input wire logic prefetch_o,
    input wire logic sleep_nop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic xtal;
    // crystal modes need the start-up count, the others resume at once
    assign xtal = fuse_word_i[2:0] <= OSC_HS;
    ////////////////////////////////////////////////////////////////
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    sleep_cause_a: assert property ($rose(asleep_o) |-> $past(core_ev_i.sleep_exec))
        else $error("sleep entered without sleep event");
    sleep_pins_a: assert property (asleep_o |-> osc_driver_off_o && io_hold_o)
        else $error("oscillator or pins not held in sleep");
    prefetch_next_a: assert property (core_ev_i.sleep_exec |=> prefetch_o)
        else $error("no prefetch after sleep event");
    nop_stays_a: assert property (sleep_nop_o |-> !asleep_o && !wake_o)
        else $error("sleep nop still slept");
    wake_awake_a: assert property (wake_o |-> !asleep_o)
        else $error("still asleep on wake");
    vector_wake_a: assert property (wake_vector_o |-> wake_o)
        else $error("vector without wake");
    reset_awake_a: assert property (device_reset_o |-> !$past(asleep_o) && !wake_o)
        else $error("watchdog reset issued from sleep");
    xtal_hold_a: assert property (wake_o && xtal |-> io_hold_o [*8])
        else $error("start-up delay cut short");
    no_ost_a: assert property (wake_o && !xtal |-> !io_hold_o)
        else $error("start-up delay in non-crystal mode");
    cover property (sleep_nop_o);
    cover property (wake_vector_o);
    cover property (device_reset_o);
endmodule // wsw_props

bind wsw_watchdog wsw_props #(.OST_COUNT(OST_COUNT)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .fuse_word_i(fuse_word_i), .core_ev_i(core_ev_i), .device_reset_o(device_reset_o),
    .asleep_o(asleep_o), .osc_driver_off_o(osc_driver_off_o), .io_hold_o(io_hold_o), .wake_o(wake_o),
    .wake_vector_o(wake_vector_o), .prefetch_o(prefetch_o), .sleep_nop_o(sleep_nop_o)
);

/* wsw_core_model.sv */
// core-side model: instruction events and interrupt flag pulses
module wsw_core_model
    import wsw_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // commands: 1 clear then sleep, 2 clear, 3 bare sleep
    input wire logic [1:0] cmd_i,
    input wire logic [10:0] irq_i,
    // towards the block
    output wsw_pkg::wsw_core_ev_t core_ev_o,
    output wsw_pkg::wsw_irq_src_t irq_src_o
);
    logic sleep_q;
    always_ff @(posedge clk_i) begin
        irq_src_o <= irq_i;
        core_ev_o <= '0;
        sleep_q <= 1'b0;
        if (rst_i) begin
            irq_src_o <= '0;
        end else if (sleep_q || cmd_i == 2'd3) begin
            core_ev_o.sleep_exec <= 1'b1;
        end else if (cmd_i != 2'd0) begin
            // clearing first keeps the count fresh even if sleep turns into a nop
            core_ev_o.clear_watchdog_instr_exec <= 1'b1;
            sleep_q <= cmd_i == 2'd1;
        end
    end
endmodule // wsw_core_model

/* tb_top.sv */
// self-checking bench for the watchdog and sleep/wake block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wsw_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic wb_cyc_i = 0;
    logic wb_stb_i = 0;
    logic wb_we_i = 0;
    logic [5:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] fuse_word_i = 8'h04;
    logic master_clear_i = 0;
    logic power_on = 0;
    logic osc_driver_off;
    logic prefetch;
    logic osc_period_i = 0;
    logic [1:0] cmd = '0;
    logic [10:0] irq = '0;
    wsw_core_ev_t core_ev;
    wsw_irq_src_t irq_src;
    logic device_reset_o;
    logic asleep_o;
    logic io_hold_o;
    logic wake_o;
    logic wake_vector_o;
    logic sleep_nop_o;
    logic [3:0] outs;
    logic [31:0] exp_q[$];
    int failures = 0;
    int num_checks = 0;
    assign outs = {device_reset_o, asleep_o, wake_o, sleep_nop_o};
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) osc_period_i <= ~osc_period_i;
    ////////////////////////////////////////////////////////////////
    wsw_watchdog #(.LF_DIVIDE(4), .OST_COUNT(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .fuse_word_i(fuse_word_i), .power_on_i(power_on), .master_clear_i(master_clear_i),
        .core_ev_i(core_ev), .irq_src_i(irq_src), .osc_period_i(osc_period_i),
        .device_reset_o(device_reset_o), .asleep_o(asleep_o), .osc_driver_off_o(osc_driver_off),
        .io_hold_o(io_hold_o), .wake_o(wake_o), .wake_vector_o(wake_vector_o), .prefetch_o(prefetch),
        .sleep_nop_o(sleep_nop_o));
    wsw_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .irq_i(irq),
        .core_ev_o(core_ev), .irq_src_o(irq_src));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= we ? d : 32'h0;
        if (!we) exp_q.push_back(d);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (n >= 20) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic wait_on(input int b, input int lim);
        int n = 0;
        while (outs[b] !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > lim) begin
                failures++;
                stop_test();
            end
        end
    endtask
    task automatic pulse(input logic [1:0] c, input logic [10:0] q);
        @(posedge clk_i);
        cmd <= c;
        irq <= q;
        @(posedge clk_i);
        cmd <= '0;
        irq <= '0;
    endtask
    // read data is judged where the ack is seen, oldest note first
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) check(wb_dat_o, exp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        void'($urandom(32'h3ad6af3b));
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        wb(0, OFS_WDT_CTRL, 32'h08);
        wb(0, OFS_PRESCALE, 32'hff);
        wb(0, OFS_STATUS, 32'h03);
        wb(0, 6'h24, 32'h0);
        r = $urandom;
        wb(1, OFS_WDT_CTRL, {r[31:5], r[4:1], 1'b0});
        wb(0, OFS_WDT_CTRL, {27'h0, r[4:1], 1'b0});
        wb(1, OFS_WDT_CTRL, 32'h1);
        wb(0, OFS_STATUS, 32'h07);
        wb(1, OFS_WDT_CTRL, 32'h0);
        wb(1, OFS_PRESCALE, 32'h0);
        wb(1, OFS_PERI_EN, 32'h1);
        wb(1, OFS_IRQ_CTRL, 32'h40);
        pulse(1, '0);
        wait_on(2, 20);
        wb(0, OFS_STATUS, 32'h0a);
        check(osc_driver_off, 1);
        pulse(0, 11'h1);
        wait_on(1, 20);
        check(wake_vector_o, 0);
        check(asleep_o, 0);
        wb(0, OFS_STATUS, 32'h02);
        wb(1, OFS_PERI_FLAG, 32'h0);
        wb(1, OFS_IRQ_CTRL, 32'hc0);
        pulse(1, '0);
        wait_on(2, 20);
        pulse(0, 11'h1);
        wait_on(1, 20);
        check(wake_vector_o, 1);
        wb(1, OFS_PERI_FLAG, 32'h0);
        wb(1, OFS_IRQ_CTRL, 32'h0);
        wb(1, OFS_WDT_CTRL, 32'h1);
        pulse(1, '0);
        wait_on(2, 20);
        wait_on(1, 3000);
        wb(0, OFS_STATUS, 32'h04);
        wb(1, OFS_IRQ_CTRL, 32'h40);
        pulse(0, 11'h1);
        pulse(3, '0);
        wait_on(0, 20);
        check(prefetch, 1);
        wb(0, OFS_STATUS, 32'h04);
        pulse(2, '0);
        wb(0, OFS_STATUS, 32'h07);
        wait_on(3, 3000);
        check(asleep_o, 0);
        rst_i <= 1;
        fuse_word_i <= 8'h09;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wb(0, OFS_STATUS, 32'h07);
        wb(1, OFS_PERI_EN, 32'h1);
        wb(1, OFS_IRQ_CTRL, 32'h40);
        wb(1, OFS_WDT_CTRL, 32'h16);
        pulse(1, '0);
        wait_on(2, 20);
        pulse(0, 11'h1);
        wait_on(1, 20);
        repeat (2) @(posedge clk_i);
        check(io_hold_o, 1);
        repeat (40) @(posedge clk_i);
        check(io_hold_o, 0);
        // the wake flag is still latched and would turn this sleep into a nop
        wb(1, OFS_PERI_FLAG, 32'h0);
        pulse(1, '0);
        wait_on(2, 20);
        master_clear_i <= 1;
        @(posedge clk_i);
        master_clear_i <= 0;
        repeat (2) @(posedge clk_i);
        check(asleep_o, 0);
        power_on <= 1;
        @(posedge clk_i);
        power_on <= 0;
        wb(0, OFS_STATUS, 32'h07);
        stop_test();
    end
endmodule // tb_top
